/* common/siu_regs.vh */
`ifndef SIU_REGS_VH
`define SIU_REGS_VH
// instruction field positions
`define SIU_OFS12_MSB     11
`define SIU_CP_OFS_MSB    7
`define SIU_RLIST_W       16
`define SIU_BIT_P         24
`define SIU_BIT_U         23
`define SIU_BIT_BSN       22
`define SIU_BIT_W         21
`define SIU_BIT_I         25
// op class codes
`define SIU_OP_NONE       2'h0
`define SIU_OP_WORD       2'h1
`define SIU_OP_MULTI      2'h2
`define SIU_OP_COPROC     2'h3
// pc status bits: mode in [1:0], flags in [31:26]
`define SIU_PC_ADDR_MASK  32'h03fffffc
// pc offsets from the store instruction, in bytes
`define SIU_PC_AHEAD_BASE 32'h00000008
`define SIU_PC_AHEAD_LIST 32'h0000000c
`endif

/* hdl/siu_shifter.v */
`timescale 1ns/1ns
`include "siu_regs.vh"
// immediate-count barrel shifter for the register offset
module siu_shifter (
  input  wire [31:0] value_in,   // offset register value
  input  wire [1:0]  shift_type, // 0 lsl 1 lsr 2 asr 3 ror
  input  wire [4:0]  shift_amt,  // constant count
  input  wire        carry_in,   // carry for rotate-with-extend
  output reg  [31:0] value_out   // shifted value
);
  wire [63:0] rot_src = {value_in, value_in};
  // a zero count on lsr/asr/ror encodes 32 / rrx, matching the encoding
  always @* begin
    case (shift_type)
      2'h0: value_out = value_in << shift_amt;
      2'h1: value_out = (shift_amt == 5'h00) ? 32'h00000000 : value_in >> shift_amt;
      2'h2: begin
        // kept out of a ternary: an unsigned partner operand would make >>> logical
        if (shift_amt == 5'h00) begin
          value_out = {32{value_in[31]}};
        end else begin
          value_out = $signed(value_in) >>> shift_amt;
        end
      end
      default: value_out = (shift_amt == 5'h00) ? {carry_in, value_in[31:1]} :
                           rot_src[shift_amt +: 32];
    endcase
  end
endmodule

/* hdl/siu_regbank.v */
`timescale 1ns/1ns
`include "siu_regs.vh"
// register list scanner: picks the lowest pending register each step
module siu_regbank (
  input  wire [15:0] pending,   // registers still to store
  output reg  [3:0]  first_idx, // lowest pending index
  output wire        any_left,  // at least one pending
  output reg  [4:0]  count      // number of bits set
);
  integer i;
  assign any_left = |pending;
  always @* begin
    first_idx = 4'h0;
    count = 5'h00;
    for (i = 15; i >= 0; i = i - 1) begin
      if (pending[i]) begin
        first_idx = i[3:0];
        count = count + 5'h01;
      end
    end
  end
endmodule

/* hdl/siu_store_unit.v */
`timescale 1ns/1ns
`include "siu_regs.vh"
module siu_store_unit (
  input  wire        clk,          // processor clock
  input  wire        rst,          // synchronous reset, active high
  input  wire        start,        // sequencer issues a store, one-cycle pulse
  input  wire [1:0]  op_class,     // word, multiple or coproc store
  input  wire [31:0] instr,        // instruction word
  input  wire [31:0] instr_addr,   // address of the store instruction
  input  wire [1:0]  cpu_mode,     // 0 means user mode
  input  wire        carry_flag,   // carry for rotate-with-extend
  input  wire [31:0] pc_status,    // pc register including status bits
  output reg  [3:0]  rf_rd_idx,    // register file read index
  output reg         rf_rd_user,   // read from user bank
  input  wire [31:0] rf_rd_data,   // register file read data, same cycle
  output reg  [3:0]  rf_rd2_idx,   // second read port index
  input  wire [31:0] rf_rd2_data,  // second read data, same cycle
  output reg         rf_wr_en,     // base write-back pulse
  output reg  [3:0]  rf_wr_idx,    // base register index
  output reg  [31:0] rf_wr_data,   // new base value
  output reg         mem_req,      // memory write request, pulse
  output reg  [31:0] mem_addr,     // memory address
  output reg  [31:0] mem_wdata,    // write data
  output reg         mem_byte,     // byte transfer
  output reg         trans_n,      // translation pin, low forces translation
  output reg         cp_req,       // coprocessor store request, pulse
  output reg  [3:0]  cp_num,       // coprocessor number
  output reg  [3:0]  cp_reg,       // coprocessor register
  output reg         cp_long,      // transfer-length bit
  output reg         busy          // store in progress
);
  localparam ST_IDLE = 3'h1;
  localparam ST_RUN  = 3'h2;
  localparam ST_WB   = 3'h4;

  reg  [2:0]  state_reg;
  reg  [15:0] pend_reg;
  reg  [31:0] addr_reg;
  reg  [31:0] final_base_reg;
  reg  [31:0] instr_reg;
  reg  [31:0] iaddr_reg;
  reg         user_reg;
  reg         wb_reg;

  wire        f_pre   = instr[`SIU_BIT_P];
  wire        f_up    = instr[`SIU_BIT_U];
  wire        f_bsn   = instr[`SIU_BIT_BSN];
  wire        f_wb    = instr[`SIU_BIT_W];
  wire        f_reg   = instr[`SIU_BIT_I];
  wire [3:0]  base_ix = instr[19:16];
  wire [3:0]  src_ix  = instr[15:12];
  wire [3:0]  ofs_ix  = instr[3:0];

  wire [31:0] shifted;
  wire [3:0]  first_idx;
  wire        any_left;
  wire [4:0]  list_cnt;

  siu_shifter u_shift (
    .value_in   ((ofs_ix == 4'hf) ? pc_status : rf_rd2_data), // pc offset keeps flags
    .shift_type (instr[6:5]),
    .shift_amt  (instr[11:7]),
    .carry_in   (carry_flag),
    .value_out  (shifted)
  );

  siu_regbank u_scan (
    .pending   ((state_reg == ST_IDLE) ? instr[15:0] : pend_reg),
    .first_idx (first_idx),
    .any_left  (any_left),
    .count     (list_cnt)
  );

  // base value: pc base used as plain address, eight ahead
  wire [31:0] pc_base   = (instr_addr + `SIU_PC_AHEAD_BASE) & `SIU_PC_ADDR_MASK;
  wire [31:0] base_val  = (base_ix == 4'hf) ? pc_base : rf_rd_data;
  // single offset: 12-bit magnitude or shifted register
  wire [31:0] word_mag  = f_reg ? shifted : {20'h00000, instr[`SIU_OFS12_MSB:0]};
  // coproc offset: 8-bit word count scaled by four
  wire [31:0] cp_mag    = {22'h000000, instr[`SIU_CP_OFS_MSB:0], 2'h0};
  wire [31:0] mag       = (op_class == `SIU_OP_COPROC) ? cp_mag : word_mag;
  // direction bit is the inverted sign
  wire [31:0] indexed   = f_up ? base_val + mag : base_val - mag;
  // pre-index uses the sum, post-index the bare base
  wire [31:0] eff_addr  = f_pre ? indexed : base_val;
  // post-index moves the base unless it is the pc; pre-index only with write-back
  wire        single_wb = !f_pre || f_wb;
  // multiple: block span and start address so lowest register lands lowest
  wire [31:0] span      = {25'h0000000, list_cnt, 2'h0};
  wire [31:0] blk_lo    = f_up ? (f_pre ? base_val + 32'h00000004 : base_val)
                               : (f_pre ? base_val - span : base_val - span + 32'h00000004);
  wire [31:0] blk_end   = f_up ? base_val + span : base_val - span;

  // register read ports: the first follows the current step, the second always reads the offset register
  always @* begin
    rf_rd2_idx = ofs_ix;
    rf_rd_user = 1'b0;
    if (state_reg == ST_RUN) begin
      rf_rd_idx  = first_idx;
      rf_rd_user = user_reg;
    end else if (state_reg == ST_IDLE) begin
      rf_rd_idx = base_ix;
    end else begin
      rf_rd_idx = src_ix;
    end
  end

  // stored value: listed pc carries status, twelve ahead
  wire [31:0] pc_list   = (iaddr_reg + `SIU_PC_AHEAD_LIST) & `SIU_PC_ADDR_MASK;
  wire [31:0] pc_listed = pc_list | (pc_status & ~`SIU_PC_ADDR_MASK);
  wire [31:0] list_data = (first_idx == 4'hf) ? pc_listed : rf_rd_data;

  // sequencer; the status word has no write path here at all
  always @(posedge clk) begin
    if (rst) begin
      state_reg      <= ST_IDLE;
      pend_reg       <= 16'h0000;
      addr_reg       <= 32'h00000000;
      final_base_reg <= 32'h00000000;
      instr_reg      <= 32'h00000000;
      iaddr_reg      <= 32'h00000000;
      user_reg       <= 1'b0;
      wb_reg         <= 1'b0;
      busy           <= 1'b0;
      mem_req        <= 1'b0;
      mem_addr       <= 32'h00000000;
      mem_wdata      <= 32'h00000000;
      mem_byte       <= 1'b0;
      trans_n        <= 1'b1;
      cp_req         <= 1'b0;
      cp_num         <= 4'h0;
      cp_reg         <= 4'h0;
      cp_long        <= 1'b0;
      rf_wr_en       <= 1'b0;
      rf_wr_idx      <= 4'h0;
      rf_wr_data     <= 32'h00000000;
    end else begin
      mem_req  <= 1'b0;
      cp_req   <= 1'b0;
      rf_wr_en <= 1'b0;
      trans_n  <= 1'b1;
      case (state_reg)
        ST_IDLE: begin
          if (start && op_class == `SIU_OP_WORD) begin
            // word store: address now, data read next cycle
            instr_reg      <= instr;
            addr_reg       <= eff_addr;
            final_base_reg <= indexed;
            wb_reg         <= single_wb;
            busy           <= 1'b1;
            state_reg      <= ST_WB;
          end else if (start && op_class == `SIU_OP_COPROC) begin
            mem_req   <= 1'b1;
            mem_addr  <= eff_addr;
            mem_byte  <= 1'b0;
            trans_n   <= 1'b1;
            cp_req    <= 1'b1;
            cp_num    <= instr[11:8];
            cp_reg    <= instr[15:12];
            cp_long   <= f_bsn;
            rf_wr_en  <= f_wb;
            rf_wr_idx <= base_ix;
            rf_wr_data <= indexed;
          end else if (start && op_class == `SIU_OP_MULTI && any_left) begin
            instr_reg      <= instr;
            iaddr_reg      <= instr_addr;
            pend_reg       <= instr[15:0];
            addr_reg       <= blk_lo;
            final_base_reg <= blk_end;
            wb_reg         <= f_wb;
            user_reg       <= f_bsn && (cpu_mode != 2'h0);
            busy           <= 1'b1;
            state_reg      <= ST_RUN;
          end
        end
        ST_RUN: begin
          // ascending addresses in ascending register order
          mem_req   <= 1'b1;
          mem_addr  <= addr_reg;
          mem_wdata <= list_data;
          mem_byte  <= 1'b0;
          addr_reg  <= addr_reg + 32'h00000004;
          pend_reg  <= pend_reg & ~(16'h0001 << first_idx);
          if (pend_reg == (16'h0001 << first_idx)) begin
            rf_wr_en   <= wb_reg;
            rf_wr_idx  <= instr_reg[19:16];
            rf_wr_data <= final_base_reg;
            busy       <= 1'b0;
            state_reg  <= ST_IDLE;
          end
        end
        ST_WB: begin
          mem_req    <= 1'b1;
          mem_addr   <= addr_reg;
          mem_byte   <= instr_reg[`SIU_BIT_BSN];
          mem_wdata  <= instr_reg[`SIU_BIT_BSN] ? {24'h000000, rf_rd_data[7:0]}
                                                : rf_rd_data;
          // translate only when post-indexed with w set
          trans_n    <= !(instr_reg[`SIU_BIT_W] && !instr_reg[`SIU_BIT_P]);
          rf_wr_en   <= wb_reg && (instr_reg[19:16] != 4'hf);
          rf_wr_idx  <= instr_reg[19:16];
          rf_wr_data <= final_base_reg;
          busy       <= 1'b0;
          state_reg  <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* verification/siu_store_unit_assertions.sv */
`timescale 1ns/1ns
module siu_store_unit_assertions (
  input wire        clk,         // processor clock
  input wire        rst,         // synchronous reset
  input wire        start,       // store issue pulse
  input wire        carry_flag,  // rotate-with-extend carry
  input wire        rf_rd_user,  // user bank read
  input wire        rf_wr_en,    // base write-back pulse
  input wire        mem_req,     // memory write pulse
  input wire        mem_byte,    // byte transfer
  input wire        trans_n,     // translation pin
  input wire        cp_req,      // coprocessor request
  input wire        cp_long,     // transfer-length bit
  input wire        busy,        // store in progress
  input wire [1:0]  op_class,    // store class
  input wire [1:0]  cpu_mode,    // processor mode
  input wire [3:0]  rf_rd_idx,   // read index
  input wire [3:0]  rf_rd2_idx,  // second read index
  input wire [3:0]  rf_wr_idx,   // write-back index
  input wire [3:0]  cp_num,      // coprocessor number
  input wire [3:0]  cp_reg,      // coprocessor register
  input wire [31:0] instr,       // instruction word
  input wire [31:0] instr_addr,  // instruction address
  input wire [31:0] pc_status,   // pc with status
  input wire [31:0] rf_rd_data,  // read data
  input wire [31:0] rf_rd2_data, // second read data
  input wire [31:0] rf_wr_data,  // write-back value
  input wire [31:0] mem_addr,    // memory address
  input wire [31:0] mem_wdata    // memory write data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // a start only counts while idle
  wire take = start && !busy;
  a_word_timing: assert property (take && op_class == 2'h1 |=> busy ##1 (mem_req && !busy))
    else $error("word store timing wrong");
  a_word_post: assert property (take && op_class == 2'h1 && !instr[24] && instr[19:16] != 4'hf
    |-> ##2 mem_addr == $past(rf_rd_data, 2) && trans_n == !$past(instr[21], 2))
    else $error("post-index word address or translation wrong");
  a_word_pre: assert property (take && op_class == 2'h1 && instr[24] |-> ##2 mem_req && trans_n)
    else $error("pre-index word store translated");
  a_cp_fields: assert property (take && op_class == 2'h3 |=> cp_req && mem_req
    && cp_num == $past(instr[11:8]) && cp_reg == $past(instr[15:12]))
    else $error("coproc request fields wrong");
  a_cp_long: assert property (cp_req |-> cp_long == $past(instr[22]))
    else $error("transfer-length bit wrong");
  a_cp_no_tr: assert property (cp_req |-> trans_n)
    else $error("coproc store translated");
  // a later mem_req in a burst climbs one word; a fresh start breaks the burst
  a_multi_up: assert property (mem_req && $past(mem_req) && !$past(start)
    |-> mem_addr == $past(mem_addr) + 32'h4)
    else $error("block addresses not ascending");
  // three or more entries keep the window inside the burst and its closing edge
  a_multi_nowb: assert property (take && op_class == 2'h2 && !instr[21]
    && $countones(instr[15:0]) >= 3 |=> !rf_wr_en [*4])
    else $error("base written back without request");
  a_multi_one: assert property (take && op_class == 2'h2 && instr[15:0] == 16'h0010
    |=> (busy && !mem_req) ##1 (mem_req && !busy))
    else $error("single-entry list not one transfer");
  a_tr_mem: assert property (!trans_n |-> mem_req && !cp_req)
    else $error("translation pin outside a memory write");
  c_multi: cover property (take && op_class == 2'h2);
  c_cp: cover property (cp_req);
  c_tr: cover property (!trans_n);
endmodule

/* verification/siu_mem_model.sv */
`timescale 1ns/1ns
module siu_mem_model (
  input wire        clk,       // processor clock
  input wire        mem_req,   // write strobe
  input wire        mem_byte,  // byte transfer
  input wire        trans_n,   // translation pin
  input wire        cp_req,    // coprocessor strobe
  input wire        cp_long,   // transfer-length bit
  input wire [31:0] mem_addr,  // address
  input wire [31:0] mem_wdata, // write data
  input wire [3:0]  cp_num,    // coprocessor number
  input wire [3:0]  cp_reg     // coprocessor register
);
  logic [31:0] la [64];
  logic [31:0] ld [64];
  logic [1:0]  lf [64];
  logic [5:0]  n = 6'h0;
  logic [8:0]  cp_seen = 9'h0;
  // write log; a byte write keeps only the low lane
  always @(posedge clk) begin
    if (mem_req) begin
      la[n] <= mem_addr;
      ld[n] <= mem_byte ? {24'h0, mem_wdata[7:0]} : mem_wdata;
      lf[n] <= {mem_byte, trans_n};
      n <= n + 6'h1;
    end
    if (cp_req) cp_seen <= {cp_long, cp_num, cp_reg};
  end
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ns
`include "siu_regs.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_top;
  logic        clk, rst, start, carry_flag, rf_rd_user, rf_wr_en, mem_req, mem_byte;
  logic        trans_n, cp_req, cp_long, busy;
  logic [1:0]  op_class, cpu_mode, t;
  logic [3:0]  rf_rd_idx, rf_rd2_idx, rf_wr_idx, cp_num, cp_reg, wb_idx;
  logic [4:0]  a;
  logic [31:0] instr, instr_addr, pc_status, rf_rd_data, rf_rd2_data, rf_wr_data;
  logic [31:0] mem_addr, mem_wdata, wb_val, lo, sh, rf [16];
  logic [5:0]  n0;
  int          num_errors = 0, checks_done = 0, cyc = 0, wb_n = 0, w0;
  // register file stand-in: a user-bank read shows a marked copy, so a stray one is seen
  assign rf_rd_data = rf[rf_rd_idx] ^ (rf_rd_user ? 32'h00f00000 : 32'h0);
  assign rf_rd2_data = rf[rf_rd2_idx];
  siu_store_unit DUT (.clk, .rst, .start, .op_class, .instr, .instr_addr, .cpu_mode,
    .carry_flag, .pc_status, .rf_rd_idx, .rf_rd_user, .rf_rd_data, .rf_rd2_idx, .rf_rd2_data,
    .rf_wr_en, .rf_wr_idx, .rf_wr_data, .mem_req, .mem_addr, .mem_wdata, .mem_byte,
    .trans_n, .cp_req, .cp_num, .cp_reg, .cp_long, .busy);
  siu_mem_model MEM (.clk, .mem_req, .mem_byte, .trans_n, .cp_req, .cp_long, .mem_addr,
    .mem_wdata, .cp_num, .cp_reg);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // base write-back capture and hang guard
  always @(posedge clk) begin
    cyc++;
    if (rf_wr_en) begin
      wb_idx <= rf_wr_idx;
      wb_val <= rf_wr_data;
      wb_n <= wb_n + 1;
    end
    if (cyc == 3000) begin
      num_errors++;
      close_out();
    end
  end
  function automatic logic [31:0] wi(logic i, p, u, b, w, logic [3:0] rn, rd, logic [11:0] o);
    return {4'he, 2'b01, i, p, u, b, w, 1'b0, rn, rd, o};
  endfunction
  task automatic go(input logic [1:0] oc, input logic [31:0] ins);
    n0 = MEM.n;
    w0 = wb_n;
    @(posedge clk);
    start <= 1'b1;
    op_class <= oc;
    instr <= ins;
    @(posedge clk);
    start <= 1'b0;
    repeat (2) @(posedge clk);
    for (int k = 0; k < 40 && busy !== 1'b0; k++) @(posedge clk);
    @(posedge clk);
    $display("op %0d done", oc);
  endtask
  task automatic chk_mem(input logic [5:0] i, input logic [31:0] ea, d, input logic [1:0] f);
    `CHK(MEM.la[n0 + i], ea)
    `CHK(MEM.ld[n0 + i], d)
    `CHK(MEM.lf[n0 + i], f)
  endtask
  task automatic chk_wb(input logic [3:0] idx, input logic [31:0] v);
    `CHK(wb_n - w0, 1)
    `CHK(wb_idx, idx)
    `CHK(wb_val, v)
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {rst, start, op_class, instr, cpu_mode, carry_flag} = {1'b1, 38'h0};
    instr_addr = 32'h00001000;
    pc_status = 32'ha4001003;
    for (int i = 0; i < 15; i++) rf[i] = 32'h00010200 * i;
    rf[5] = 32'h80000300;
    rf[15] = pc_status;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    // word-aligned bases throughout, as software must keep them
    go(2'h1, wi(0, 0, 1, 0, 0, 4'h1, 4'h2, 12'h010));
    chk_mem(0, rf[1], rf[2], 2'b01);
    chk_wb(4'h1, rf[1] + 32'h10);
    go(2'h1, wi(0, 1, 0, 1, 1, 4'h3, 4'h4, 12'hfff));
    chk_mem(0, rf[3] - 32'hfff, {24'h0, rf[4][7:0]}, 2'b11);
    chk_wb(4'h3, rf[3] - 32'hfff);
    go(2'h1, wi(0, 0, 1, 0, 1, 4'h1, 4'h2, 12'h0));
    chk_mem(0, rf[1], rf[2], 2'b00);
    go(2'h1, wi(0, 1, 1, 0, 1, 4'hf, 4'h2, 12'h004));
    chk_mem(0, ((instr_addr + 8) & `SIU_PC_ADDR_MASK) + 4, rf[2], 2'b01);
    `CHK(wb_n - w0, 0)
    // four shift kinds by three, then rotate-with-extend through the carry
    carry_flag <= 1'b1;
    for (int k = 0; k < 5; k++) begin
      t = (k == 4) ? 2'h3 : k[1:0];
      a = (k == 4) ? 5'h0 : 5'h3;
      case (k)
        0: sh = rf[5] << 3;
        1: sh = rf[5] >> 3;
        2: sh = $signed(rf[5]) >>> 3;
        3: sh = {rf[5][2:0], rf[5][31:3]};
        default: sh = {1'b1, rf[5][31:1]};
      endcase
      go(2'h1, wi(1, 1, 1, 0, 0, 4'h1, 4'h2, {a, t, 1'b0, 4'h5}));
      chk_mem(0, rf[1] + sh, rf[2], 2'b01);
    end
    // list r1, r3, pc in each mode; last mode leaves the base alone
    for (int m = 0; m < 4; m++) begin
      lo = m[0] ? (m[1] ? rf[2] + 4 : rf[2]) : (m[1] ? rf[2] - 12 : rf[2] - 8);
      go(2'h2, {4'he, 3'b100, m[1], m[0], 1'b0, m != 3, 1'b0, 4'h2, 16'h800a});
      `CHK(MEM.n - n0, 6'd3)
      chk_mem(0, lo, rf[1], 2'b01);
      chk_mem(1, lo + 4, rf[3], 2'b01);
      chk_mem(2, lo + 8, ((instr_addr + 12) & `SIU_PC_ADDR_MASK)
        | (pc_status & ~`SIU_PC_ADDR_MASK), 2'b01);
      if (m != 3) chk_wb(4'h2, m[0] ? rf[2] + 12 : rf[2] - 12);
      else `CHK(wb_n - w0, 0)
    end
    for (int m = 0; m < 2; m++) begin
      cpu_mode <= m ? 2'h3 : 2'h0;
      go(2'h2, {4'he, 3'b100, 2'b01, 1'b1, 2'b00, 4'h2, 16'h0010});
      chk_mem(0, rf[2], rf[4] ^ (m ? 32'h00f00000 : 32'h0), 2'b01);
    end
    cpu_mode <= 2'h0;
    go(2'h3, {4'he, 3'b110, 4'b1011, 1'b0, 4'h1, 4'h9, 4'h5, 8'hff});
    `CHK(MEM.la[n0], rf[1] - 32'h3fc)
    `CHK(MEM.cp_seen, {1'b1, 4'h5, 4'h9})
    chk_wb(4'h1, rf[1] - 32'h3fc);
    go(2'h3, {4'he, 3'b110, 4'b0100, 1'b0, 4'hf, 4'h0, 4'hc, 8'h01});
    `CHK(MEM.la[n0], (instr_addr + 8) & `SIU_PC_ADDR_MASK)
    `CHK(MEM.cp_seen, {1'b0, 4'hc, 4'h0})
    go(2'h2, {4'he, 3'b100, 4'b0100, 1'b0, 4'h2, 16'h0000});
    `CHK(MEM.n - n0, 6'd0)
    close_out();
  end
endmodule
bind siu_store_unit siu_store_unit_assertions CHK_U (.clk, .rst, .start, .carry_flag,
  .rf_rd_user, .rf_wr_en, .mem_req, .mem_byte, .trans_n, .cp_req, .cp_long, .busy, .op_class,
  .cpu_mode, .rf_rd_idx, .rf_rd2_idx, .rf_wr_idx, .cp_num, .cp_reg, .instr, .instr_addr,
  .pc_status, .rf_rd_data, .rf_rd2_data, .rf_wr_data, .mem_addr, .mem_wdata);
